// ---- eepwr_map.vh ----
// constants for the byte-wide eeprom write sequencer
`ifndef EEPWR_MAP_VH
`define EEPWR_MAP_VH
// ----------
// clock
// ----------
`define EEPWR_CLK_MHZ 50
`define EEPWR_CLK_KHZ 50000
// ----------
// times as printed, and cycle counts derived from them
// ----------
`define EEPWR_WP_NS 250
`define EEPWR_ACC_NS 250
`define EEPWR_DW_NS 250
`define EEPWR_BLC_MIN_NS 1000
`define EEPWR_BLC_MAX_US 30
`define EEPWR_BL_US 100
`define EEPWR_WC_MS 15
`define EEPWR_RES_HOLD_MS 10
`define EEPWR_NS2CYC(ns) (((ns) * `EEPWR_CLK_MHZ + 999) / 1000)
`define EEPWR_WP_CYC `EEPWR_NS2CYC(`EEPWR_WP_NS)
`define EEPWR_ACC_CYC `EEPWR_NS2CYC(`EEPWR_ACC_NS)
`define EEPWR_DW_CYC `EEPWR_NS2CYC(`EEPWR_DW_NS)
`define EEPWR_BLC_MIN_CYC `EEPWR_NS2CYC(`EEPWR_BLC_MIN_NS)
`define EEPWR_BLC_MAX_CYC (`EEPWR_BLC_MAX_US * `EEPWR_CLK_MHZ)
`define EEPWR_BL_CYC (`EEPWR_BL_US * `EEPWR_CLK_MHZ)
`define EEPWR_WC_CYC (`EEPWR_WC_MS * `EEPWR_CLK_KHZ)
`define EEPWR_RES_HOLD_CYC (`EEPWR_RES_HOLD_MS * `EEPWR_CLK_KHZ)
`define EEPWR_SYNC_LAT 3
`define EEPWR_READY_MARGIN 4
// ----------
// geometry
// ----------
`define EEPWR_AW 17
`define EEPWR_DW 8
`define EEPWR_PAGE_BYTES 128
// ----------
// commands
// ----------
`define EEPWR_OP_WRITE 2'h0
`define EEPWR_OP_READ 2'h1
`define EEPWR_OP_UNPROT 2'h2
`define EEPWR_OP_PROTW 2'h3
// ----------
// completion methods
// ----------
`define EEPWR_DONE_TIMED 2'h0
`define EEPWR_DONE_POLL 2'h1
`define EEPWR_DONE_TOGGLE 2'h2
`define EEPWR_DONE_BUSY 2'h3
// ----------
// unlock addresses, data and step counts
// ----------
`define EEPWR_ADR_A 17'h05555
`define EEPWR_ADR_B 17'h02AAA
`define EEPWR_D_AA 8'hAA
`define EEPWR_D_55 8'h55
`define EEPWR_D_80 8'h80
`define EEPWR_D_20 8'h20
`define EEPWR_D_A0 8'hA0
`define EEPWR_PRE_STEPS 3'h3
`define EEPWR_CANCEL_LAST 3'h5
`define EEPWR_POLL_BIT 7
`define EEPWR_TOGGLE_BIT 6
`endif

// ---- eepwr_sync.v ----
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module eepwr_sync #(
  parameter W = 1
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // asynchronous levels in, filtered levels out
  input wire [W-1:0] async_i,
  output reg [W-1:0] sync_o
);
  // ----------
  // stages
  // ----------
  reg [W-1:0] s1_r; // first stage, read only by s2_r
  reg [W-1:0] s2_r; // second stage
  reg [W-1:0] s3_r; // third stage
  genvar g;

  // shift chain
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
      s3_r <= {W{1'b0}};
    end else begin
      s1_r <= async_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // per bit: take the new level once stages two and three agree
  generate
    for (g = 0; g < W; g = g + 1) begin : bit_g
      always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          sync_o[g] <= 1'b0;
        end else if (s2_r[g] == s3_r[g]) begin
          sync_o[g] <= s3_r[g];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ---- eepwr_ctrl.v ----
// host-side write sequencer for a byte-wide eeprom
// ----------
// Summary of operation
// - six-write sequence cancels software protection
// - protected writes need three-write preamble first
// - keep reset high 10 ms after last load
// - hold reset low while power switches
// - next byte load within 30 us
// - write finishes within 15 ms
// - with status checks, next access after 250 ns
// ----------
`timescale 1ns/1ps
`default_nettype none
`include "eepwr_map.vh"
module eepwr_ctrl #(
  parameter WC_CYC = `EEPWR_WC_CYC,
  parameter BL_CYC = `EEPWR_BL_CYC,
  parameter RES_HOLD_CYC = `EEPWR_RES_HOLD_CYC
) (
  // clock and reset
  input wire CLK_I,
  input wire RST_I,
  // command port
  input wire CMD_VALID_I,
  input wire [1:0] CMD_OP_I,
  input wire [`EEPWR_AW-1:0] CMD_ADDR_I,
  input wire [`EEPWR_DW-1:0] CMD_DATA_I,
  input wire CMD_LAST_I,
  input wire [1:0] DONE_MODE_I,
  input wire PWR_GOOD_I,
  output reg CMD_READY_O,
  // answers and status
  output reg [`EEPWR_DW-1:0] RD_DATA_O,
  output reg RD_VALID_O,
  output reg DONE_O,
  output reg BUSY_O,
  output reg PROT_O,
  // memory pins
  output reg [`EEPWR_AW-1:0] MEM_ADDR_O,
  input wire [`EEPWR_DW-1:0] MEM_DQ_I,
  output reg [`EEPWR_DW-1:0] MEM_DQ_O,
  output reg MEM_DQ_OE_O,
  output reg MEM_CE_N_O,
  output reg MEM_OE_N_O,
  output reg MEM_WE_N_O,
  output reg PROGRAM_RESET_IN_N_O,
  input wire MEM_BUSY_N_I
);
  // ----------
  // states
  // ----------
  localparam S_IDLE = 9'h001; // waiting for a command
  localparam S_SETUP = 9'h002; // address, data, chip select set
  localparam S_STRB = 9'h004; // write strobe low
  localparam S_GAP = 9'h008; // strobe high, byte load cycle minimum
  localparam S_LWAIT = 9'h010; // page open, next byte may come
  localparam S_SETTLE = 9'h020; // load window runs out, write starts
  localparam S_PREAD = 9'h040; // status or user read in flight
  localparam S_PEVAL = 9'h080; // judge status read
  localparam S_PGAP = 9'h100; // strobes high between status reads

  // ----------
  // declarations
  // ----------
  reg [8:0] state_r; // current state
  reg [19:0] cnt_r; // cycles since last strobe fall or read start
  reg [19:0] wcnt_r; // cycles since last data load
  reg [1:0] op_r; // command in progress
  reg [2:0] step_r; // step in an unlock sequence
  reg pre_r; // preamble being sent
  reg [`EEPWR_AW-1:0] uaddr_r; // user address of current byte
  reg [`EEPWR_DW-1:0] udata_r; // user data of current byte
  reg [`EEPWR_DW-1:0] last_r; // last byte loaded, for polling
  reg [7:0] page_r; // bytes loaded into the page
  reg close_r; // page closed by user
  reg tog_ok_r; // a previous toggle sample exists
  reg tog_r; // previous toggle sample
  reg tog_stop_r; // two status samples agree on bit six
  reg rd_user_r; // read belongs to the user
  reg wr_active_r; // a write cycle may be in progress
  wire [`EEPWR_DW+1:0] sync_w; // {busy_n, dq, power}
  wire pwr_ok_w; // power good, synchronised
  wire [`EEPWR_DW-1:0] dq_w; // data pins, synchronised
  wire busy_n_w; // busy pin, synchronised
  wire take_w; // command accepted this cycle
  wire cancel_w; // sequence is the protection cancel
  wire last_step_w; // this step is the final load of the command

  // ----------
  // functions
  // ----------
  // address of an unlock step; steps 1 and 4 use the second address
  function [`EEPWR_AW-1:0] step_addr;
    input [2:0] idx;
    begin
      step_addr = (idx == 3'h1 || idx == 3'h4) ? `EEPWR_ADR_B : `EEPWR_ADR_A;
    end
  endfunction

  // data of an unlock step
  function [`EEPWR_DW-1:0] step_data;
    input cancel;
    input [2:0] idx;
    begin
      case (idx)
        3'h0: step_data = `EEPWR_D_AA;
        3'h1: step_data = `EEPWR_D_55;
        3'h2: step_data = cancel ? `EEPWR_D_80 : `EEPWR_D_A0;
        3'h3: step_data = `EEPWR_D_AA;
        3'h4: step_data = `EEPWR_D_55;
        default: step_data = `EEPWR_D_20;
      endcase
    end
  endfunction

  // ----------
  // input synchroniser
  // ----------
  eepwr_sync #(
    .W(`EEPWR_DW + 2)
  ) u_sync (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .async_i({MEM_BUSY_N_I, MEM_DQ_I, PWR_GOOD_I}),
    .sync_o(sync_w)
  );
  assign pwr_ok_w = sync_w[0];
  assign dq_w = sync_w[`EEPWR_DW:1];
  assign busy_n_w = sync_w[`EEPWR_DW+1];

  assign take_w = CMD_VALID_I & CMD_READY_O;
  assign cancel_w = (op_r == `EEPWR_OP_UNPROT);
  assign last_step_w = cancel_w ? (step_r == `EEPWR_CANCEL_LAST) : ~pre_r;

  // ----------
  // reset pin: low while power switches, but not inside a write until the hold time after the last load has run
  // ----------
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      PROGRAM_RESET_IN_N_O <= 1'b0; // held low until power is good
    end else if (pwr_ok_w) begin
      PROGRAM_RESET_IN_N_O <= 1'b1;
    end else if (!wr_active_r || wcnt_r >= RES_HOLD_CYC) begin
      PROGRAM_RESET_IN_N_O <= 1'b0;
    end
  end

  // ----------
  // sequencer
  // ----------
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_r <= S_IDLE;
      cnt_r <= 20'h00000;
      wcnt_r <= 20'h00000;
      op_r <= `EEPWR_OP_WRITE;
      step_r <= 3'h0;
      pre_r <= 1'b0;
      uaddr_r <= {`EEPWR_AW{1'b0}};
      udata_r <= {`EEPWR_DW{1'b0}};
      last_r <= {`EEPWR_DW{1'b0}};
      page_r <= 8'h00;
      close_r <= 1'b0;
      tog_ok_r <= 1'b0;
      tog_r <= 1'b0;
      tog_stop_r <= 1'b0;
      rd_user_r <= 1'b0;
      wr_active_r <= 1'b0;
      CMD_READY_O <= 1'b0;
      RD_DATA_O <= {`EEPWR_DW{1'b0}};
      RD_VALID_O <= 1'b0;
      DONE_O <= 1'b0;
      BUSY_O <= 1'b0;
      PROT_O <= 1'b0;
      MEM_ADDR_O <= {`EEPWR_AW{1'b0}};
      MEM_DQ_O <= {`EEPWR_DW{1'b0}};
      MEM_DQ_OE_O <= 1'b0;
      MEM_CE_N_O <= 1'b1;
      MEM_OE_N_O <= 1'b1;
      MEM_WE_N_O <= 1'b1;
    end else begin
      RD_VALID_O <= 1'b0;
      DONE_O <= 1'b0;
      if (wcnt_r != 20'hFFFFF) begin
        wcnt_r <= wcnt_r + 20'h00001;
      end
      case (state_r)
        // accept a command only while the reset pin is released
        S_IDLE: begin
          CMD_READY_O <= pwr_ok_w & PROGRAM_RESET_IN_N_O;
          if (take_w) begin
            CMD_READY_O <= 1'b0;
            BUSY_O <= 1'b1;
            op_r <= CMD_OP_I;
            uaddr_r <= CMD_ADDR_I;
            udata_r <= CMD_DATA_I;
            close_r <= CMD_LAST_I;
            page_r <= 8'h00;
            step_r <= 3'h0;
            tog_ok_r <= 1'b0;
            tog_stop_r <= 1'b0; // no stale toggle verdict
            cnt_r <= 20'h00000;
            if (CMD_OP_I == `EEPWR_OP_READ) begin
              rd_user_r <= 1'b1;
              MEM_ADDR_O <= CMD_ADDR_I;
              MEM_CE_N_O <= 1'b0;
              MEM_OE_N_O <= 1'b0;
              state_r <= S_PREAD;
            end else begin
              // preamble when protected, to enable protection, or to cancel
              pre_r <= PROT_O | (CMD_OP_I != `EEPWR_OP_WRITE);
              state_r <= S_SETUP;
            end
          end
        end
        // present address and data with chip select low
        S_SETUP: begin
          MEM_ADDR_O <= pre_r ? step_addr(step_r) : uaddr_r;
          MEM_DQ_O <= pre_r ? step_data(cancel_w, step_r) : udata_r;
          MEM_DQ_OE_O <= 1'b1;
          MEM_CE_N_O <= 1'b0;
          MEM_WE_N_O <= 1'b0; // falls with chip select: address latched here
          cnt_r <= 20'h00000;
          wr_active_r <= 1'b1;
          state_r <= S_STRB;
        end
        // strobe width far above the glitch filter width
        S_STRB: begin
          cnt_r <= cnt_r + 20'h00001;
          if (cnt_r >= `EEPWR_WP_CYC - 1) begin
            MEM_WE_N_O <= 1'b1; // rising edge latches data
            wcnt_r <= 20'h00000;
            if (!pre_r) begin
              last_r <= udata_r;
              page_r <= page_r + 8'h01;
            end
            state_r <= S_GAP;
          end
        end
        // hold data, then keep the byte load cycle minimum
        S_GAP: begin
          cnt_r <= cnt_r + 20'h00001;
          if (cnt_r >= `EEPWR_BLC_MIN_CYC - 1) begin
            MEM_DQ_OE_O <= 1'b0;
            MEM_CE_N_O <= 1'b1;
            if (!last_step_w) begin
              // cancel steps go on; preamble ends before the user byte
              step_r <= step_r + 3'h1;
              if (!cancel_w && step_r == `EEPWR_PRE_STEPS - 3'h1) begin
                pre_r <= 1'b0;
              end
              state_r <= S_SETUP;
            end else begin
              if (op_r == `EEPWR_OP_PROTW) begin
                PROT_O <= 1'b1;
              end
              if (cancel_w) begin
                PROT_O <= 1'b0; // no user byte follows
              end
              CMD_READY_O <= ~close_r & ~cancel_w & (page_r < `EEPWR_PAGE_BYTES);
              state_r <= S_LWAIT;
            end
          end
        end
        // page stays open only inside the byte load cycle maximum
        S_LWAIT: begin
          cnt_r <= cnt_r + 20'h00001;
          if (take_w && CMD_OP_I == `EEPWR_OP_WRITE) begin
            CMD_READY_O <= 1'b0;
            uaddr_r <= CMD_ADDR_I;
            udata_r <= CMD_DATA_I;
            close_r <= CMD_LAST_I;
            state_r <= S_SETUP;
          end else if (close_r || cancel_w || page_r >= `EEPWR_PAGE_BYTES ||
                       cnt_r >= `EEPWR_BLC_MAX_CYC - `EEPWR_READY_MARGIN) begin
            CMD_READY_O <= 1'b0;
            state_r <= S_SETTLE;
          end
        end
        // strobes stay high for the load window, then write start time
        S_SETTLE: begin
          cnt_r <= cnt_r + 20'h00001;
          if (cnt_r >= BL_CYC + `EEPWR_DW_CYC) begin
            cnt_r <= 20'h00000;
            if (DONE_MODE_I == `EEPWR_DONE_POLL || DONE_MODE_I == `EEPWR_DONE_TOGGLE) begin
              MEM_ADDR_O <= uaddr_r;
              MEM_CE_N_O <= 1'b0;
              MEM_OE_N_O <= 1'b0;
              state_r <= S_PREAD;
            end else begin
              state_r <= S_PEVAL;
            end
          end
        end
        // wait access time plus synchroniser latency, then sample
        S_PREAD: begin
          cnt_r <= cnt_r + 20'h00001;
          if (cnt_r >= `EEPWR_ACC_CYC + `EEPWR_SYNC_LAT) begin
            MEM_CE_N_O <= 1'b1;
            MEM_OE_N_O <= 1'b1;
            cnt_r <= 20'h00000;
            tog_ok_r <= 1'b1;
            tog_r <= dq_w[`EEPWR_TOGGLE_BIT];
            tog_stop_r <= tog_ok_r & (dq_w[`EEPWR_TOGGLE_BIT] == tog_r);
            if (rd_user_r) begin
              rd_user_r <= 1'b0;
              RD_DATA_O <= dq_w;
              RD_VALID_O <= 1'b1;
              DONE_O <= 1'b1;
              BUSY_O <= 1'b0;
              state_r <= S_IDLE;
            end else begin
              state_r <= S_PEVAL;
            end
          end
        end
        // decide whether the internal write has finished
        S_PEVAL: begin
          if (wcnt_r >= WC_CYC ||
              (DONE_MODE_I == `EEPWR_DONE_POLL && !cancel_w &&
               dq_w[`EEPWR_POLL_BIT] == last_r[`EEPWR_POLL_BIT]) ||
              (DONE_MODE_I == `EEPWR_DONE_TOGGLE && !cancel_w && tog_stop_r) ||
              (DONE_MODE_I == `EEPWR_DONE_BUSY && !cancel_w && busy_n_w)) begin
            wr_active_r <= 1'b0;
            DONE_O <= 1'b1;
            BUSY_O <= 1'b0;
            state_r <= S_IDLE;
          end else begin
            cnt_r <= 20'h00000;
            state_r <= S_PGAP;
          end
        end
        // strobes high between status reads
        S_PGAP: begin
          cnt_r <= cnt_r + 20'h00001;
          if (cnt_r >= `EEPWR_DW_CYC) begin
            cnt_r <= 20'h00000;
            if (DONE_MODE_I == `EEPWR_DONE_POLL || DONE_MODE_I == `EEPWR_DONE_TOGGLE) begin
              MEM_CE_N_O <= 1'b0;
              MEM_OE_N_O <= 1'b0;
              state_r <= S_PREAD;
            end else begin
              state_r <= S_PEVAL;
            end
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- eepwr_dev_model.sv ----
// behavioural byte-wide eeprom with page load, status reads and protection
`timescale 1ns/1ps
`default_nettype none
module eepwr_dev_model #(
  parameter int BL = 150
) (
  // timer clock
  input wire logic clk_i,
  // control and address pins from the host
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic res_n_i,
  input wire logic [16:0] addr_i,
  input wire logic [7:0] dq_i,
  // pins back to the host
  output wire logic [7:0] dq_o,
  output wire logic busy_n_o,
  // internal write time in cycles, slow or prompt
  input wire logic [15:0] wc_cyc_i
);
  // ----------
  // array, page latches and state
  // ----------
  logic [7:0] mem [0:131071];
  logic [16:0] pa [0:127];
  logic [7:0] pd [0:127];
  logic [16:0] la = 17'h00000;
  logic [7:0] last = 8'h00;
  logic [7:0] drv = 8'h00;
  logic busy = 1'b0;
  logic tog = 1'b0;
  logic prot = 1'b0;
  int pn = 0;
  int idle = 0;
  int wcnt = 0;
  int st = 0;
  realtime t0 = 0.0;
  // strobes as the array sees them; nothing passes while reset is low
  wire logic wr = !ce_n_i && !we_n_i && res_n_i;
  wire logic rd = !ce_n_i && !oe_n_i && we_n_i && res_n_i;
  assign busy_n_o = busy ? 1'b0 : 1'bz;
  // released data lines show the inverse of the last value
  assign dq_o = rd ? drv : ~drv;
  initial begin
    for (int i = 0; i < 131072; i++) mem[i] = 8'hFF;
  end
  // queue one byte for the page
  task automatic keep(input logic [16:0] a, input logic [7:0] d);
    if (pn < 128) begin
      pa[pn] = a;
      pd[pn] = d;
      pn++;
    end
    last = d;
  endtask
  // unlock tracker, one step per data latch
  task automatic load(input logic [16:0] a, input logic [7:0] d);
    logic u5, u2;
    u5 = (a == 17'h05555);
    u2 = (a == 17'h02AAA) || (a == 17'h0AAAA);
    case (st)
      0: st = (u5 && d == 8'hAA) ? 1 : 0;
      1: st = (u2 && d == 8'h55) ? 2 : 0;
      2: begin
        if (u5 && d == 8'hA0) prot = 1'b1;
        st = (u5 && d == 8'hA0) ? 6 : (u5 && d == 8'h80) ? 3 : 0;
      end
      3: st = (u5 && d == 8'hAA) ? 4 : 0;
      4: st = (u2 && d == 8'h55) ? 5 : 0;
      5: begin
        if (u5 && d == 8'h20) prot = 1'b0;
        st = 0;
      end
      default: begin
        keep(a, d);
        st = 0;
      end
    endcase
  endtask
  // address on the later fall, data on the first rise, short pulses dropped
  always @(posedge wr) begin
    la = addr_i;
    t0 = $realtime;
  end
  always @(negedge wr) begin
    if (res_n_i && ($realtime - t0) > 20.0 && wcnt == 0) begin
      busy = 1'b1;
      idle = 0;
      if (st == 0 && !prot && !(la == 17'h05555 && dq_i == 8'hAA)) keep(la, dq_i);
      else load(la, dq_i);
    end
  end
  // status reads: inverted bit 7 and toggling bit 6 while busy
  always @(posedge rd) begin
    if (busy) begin
      drv = {~last[7], tog, mem[addr_i][5:0]};
      tog = ~tog;
    end else begin
      drv = mem[addr_i];
    end
  end
  // load window, internal write and abort by reset
  always @(posedge clk_i) begin
    if (!res_n_i) begin
      if (wcnt > 0) for (int i = 0; i < pn; i++) mem[pa[i]] = ~pd[i];
      busy = 1'b0;
      pn = 0;
      wcnt = 0;
      idle = 0;
    end else if (wcnt > 0) begin
      wcnt--;
      if (wcnt == 0) begin
        for (int i = 0; i < pn; i++) mem[pa[i]] = pd[i];
        pn = 0;
        busy = 1'b0;
      end
    end else if (busy && !wr) begin
      idle++;
      if (idle >= BL) wcnt = int'(wc_cyc_i);
    end
  end
endmodule
`default_nettype wire

// ---- eepwr_ctrl_asserts.sv ----
// concurrent checks on the eeprom write sequencer ports
`timescale 1ns/1ps
`default_nettype none
module eepwr_ctrl_asserts #(
  parameter int WC_CYC = 750000,
  parameter int BL_CYC = 5000,
  parameter int RES_HOLD_CYC = 500000
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // inputs watched
  input wire logic [1:0] DONE_MODE_I,
  input wire logic PWR_GOOD_I,
  // answers
  input wire logic DONE_O,
  input wire logic RD_VALID_O,
  input wire logic PROT_O,
  // memory pins
  input wire logic [16:0] MEM_ADDR_O,
  input wire logic [7:0] MEM_DQ_O,
  input wire logic MEM_CE_N_O,
  input wire logic MEM_OE_N_O,
  input wire logic MEM_WE_N_O,
  input wire logic PROGRAM_RESET_IN_N_O
);
  localparam int LOAD_GAP_MAX = 1500;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  // cycles since last strobe rise and fall, previous load, write finished
  int unsigned rise_cnt, fall_cnt;
  logic done_seen, we_q;
  logic [16:0] prev_a;
  logic [7:0] prev_d;
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rise_cnt <= 32'h000FFFFF;
      fall_cnt <= 32'h000FFFFF;
      done_seen <= 1'b1;
      we_q <= 1'b1;
      prev_a <= 17'h00000;
      prev_d <= 8'h00;
    end else begin
      we_q <= MEM_WE_N_O;
      if (MEM_WE_N_O && !we_q) begin
        rise_cnt <= 32'h00000000;
        prev_a <= MEM_ADDR_O;
        prev_d <= MEM_DQ_O;
      end else if (rise_cnt < 32'h000FFFFF) rise_cnt <= rise_cnt + 32'h00000001;
      if (!MEM_WE_N_O && we_q) fall_cnt <= 32'h00000000;
      else if (fall_cnt < 32'h000FFFFF) fall_cnt <= fall_cnt + 32'h00000001;
      if (!MEM_WE_N_O && we_q) done_seen <= 1'b0;
      else if (DONE_O && !RD_VALID_O) done_seen <= 1'b1;
    end
  end
  property p_res_rise;
    $rose(PROGRAM_RESET_IN_N_O) |-> PWR_GOOD_I && $past(PWR_GOOD_I, 3);
  endproperty
  a_res_rise: assert property (p_res_rise) else $error("reset pin released without stable power");
  property p_pwr_drop;
    $fell(PWR_GOOD_I) && done_seen && MEM_CE_N_O |-> ##[1:8] !PROGRAM_RESET_IN_N_O;
  endproperty
  a_pwr_drop: assert property (p_pwr_drop) else $error("reset pin not lowered on power loss");
  property p_quiet_res;
    !PROGRAM_RESET_IN_N_O |-> MEM_CE_N_O && MEM_WE_N_O && MEM_OE_N_O;
  endproperty
  a_quiet_res: assert property (p_quiet_res) else $error("strobe active while reset pin low");
  property p_hold;
    $fell(PROGRAM_RESET_IN_N_O) |-> done_seen || rise_cnt >= RES_HOLD_CYC - 1;
  endproperty
  a_hold: assert property (p_hold) else $error("reset pin lowered too soon after a load");
  property p_gap;
    $fell(MEM_WE_N_O) && !done_seen |-> fall_cnt <= LOAD_GAP_MAX;
  endproperty
  a_gap: assert property (p_gap) else $error("byte load started too late");
  property p_timed;
    DONE_O && !RD_VALID_O && DONE_MODE_I == 2'h0 |-> rise_cnt >= WC_CYC - 2;
  endproperty
  a_timed: assert property (p_timed) else $error("timed write finished early");
  property p_window;
    DONE_O && !RD_VALID_O |-> rise_cnt >= BL_CYC;
  endproperty
  a_window: assert property (p_window) else $error("write done before load window closed");
  property p_pre_a0;
    $rose(MEM_WE_N_O) && MEM_ADDR_O == 17'h05555 && MEM_DQ_O == 8'hA0 |-> prev_a == 17'h02AAA && prev_d == 8'h55;
  endproperty
  a_pre_a0: assert property (p_pre_a0) else $error("preamble third load out of order");
  property p_pre_cancel;
    $rose(MEM_WE_N_O) && MEM_ADDR_O == 17'h05555 && (MEM_DQ_O == 8'h80 || MEM_DQ_O == 8'h20)
      |-> prev_a == 17'h02AAA && prev_d == 8'h55;
  endproperty
  a_pre_cancel: assert property (p_pre_cancel) else $error("cancel load out of order");
  property p_step2;
    $rose(MEM_WE_N_O) && MEM_ADDR_O == 17'h02AAA && MEM_DQ_O == 8'h55 |-> prev_a == 17'h05555 && prev_d == 8'hAA;
  endproperty
  a_step2: assert property (p_step2) else $error("unlock second load out of order");
  c_write: cover property (DONE_O && !RD_VALID_O);
  c_read: cover property (RD_VALID_O);
  c_prot: cover property ($rose(PROT_O));
  c_pwr: cover property ($fell(PROGRAM_RESET_IN_N_O));
endmodule
bind eepwr_ctrl eepwr_ctrl_asserts #(.WC_CYC(WC_CYC), .BL_CYC(BL_CYC), .RES_HOLD_CYC(RES_HOLD_CYC)) u_chk (
  .CLK_I(CLK_I), .RST_I(RST_I), .DONE_MODE_I(DONE_MODE_I), .PWR_GOOD_I(PWR_GOOD_I), .DONE_O(DONE_O),
  .RD_VALID_O(RD_VALID_O), .PROT_O(PROT_O), .MEM_ADDR_O(MEM_ADDR_O), .MEM_DQ_O(MEM_DQ_O),
  .MEM_CE_N_O(MEM_CE_N_O), .MEM_OE_N_O(MEM_OE_N_O), .MEM_WE_N_O(MEM_WE_N_O),
  .PROGRAM_RESET_IN_N_O(PROGRAM_RESET_IN_N_O));
`default_nettype wire

// ---- eeprom_write_protect_sequencer_tb.sv ----
// self-checking bench for the eeprom write sequencer
`timescale 1ns/1ps
`default_nettype none
module eeprom_write_protect_sequencer_tb;
  // ----------
  // drive, wires and counters
  // ----------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic [1:0] cmd_op = 2'h0;
  logic [16:0] cmd_addr = 17'h00000;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_last = 1'b1;
  logic [1:0] done_mode = 2'h0;
  logic pwr_good = 1'b1;
  logic [15:0] wc = 16'h012C;
  int mismatches = 0;
  int check_count = 0;
  int wn = 0; // cycles of the last completion wait
  wire logic cmd_ready, rd_valid, done, busy, prot, dq_oe, ce_n, oe_n, we_n, res_n;
  wire logic [7:0] rd_data, hdq, ddq, dq_bus;
  wire logic [16:0] maddr;
  tri1 busy_n; // pulled up while the device lets go
  assign dq_bus = dq_oe ? hdq : ddq;
  always #10 clk = ~clk;
  eepwr_ctrl #(.WC_CYC(2000), .BL_CYC(200), .RES_HOLD_CYC(1000)) uut (
    .CLK_I(clk), .RST_I(rst), .CMD_VALID_I(cmd_valid), .CMD_OP_I(cmd_op), .CMD_ADDR_I(cmd_addr),
    .CMD_DATA_I(cmd_data), .CMD_LAST_I(cmd_last), .DONE_MODE_I(done_mode), .PWR_GOOD_I(pwr_good),
    .CMD_READY_O(cmd_ready), .RD_DATA_O(rd_data), .RD_VALID_O(rd_valid), .DONE_O(done), .BUSY_O(busy),
    .PROT_O(prot), .MEM_ADDR_O(maddr), .MEM_DQ_I(dq_bus), .MEM_DQ_O(hdq), .MEM_DQ_OE_O(dq_oe),
    .MEM_CE_N_O(ce_n), .MEM_OE_N_O(oe_n), .MEM_WE_N_O(we_n), .PROGRAM_RESET_IN_N_O(res_n),
    .MEM_BUSY_N_I(busy_n));
  eepwr_dev_model #(.BL(150)) dev (.clk_i(clk), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
    .res_n_i(res_n), .addr_i(maddr), .dq_i(dq_bus), .dq_o(ddq), .busy_n_o(busy_n), .wc_cyc_i(wc));
  // ----------
  // shared tasks
  // ----------
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask
  // one command, valid held until the edge that takes it
  task automatic cmd(input logic [1:0] op, input logic [16:0] a, input logic [7:0] d, input logic l);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    cmd_last = l;
    while (cmd_ready !== 1'b1 && n < 5000) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    chk({busy, n < 5000}, 8'h03);
  endtask
  // wait for the completion pulse under a bound
  task automatic wdone(output logic [8:0] v);
    int n;
    n = 0;
    while (done !== 1'b1 && n < 20000) begin
      @(posedge clk);
      #1;
      n++;
    end
    v = {rd_valid, rd_data};
    wn = n;
    chk({busy, n < 20000}, 8'h01);
  endtask
  task automatic wr(input logic [1:0] op, input logic [16:0] a, input logic [7:0] d);
    logic [8:0] v;
    cmd(op, a, d, 1'b1);
    wdone(v);
    chk(v[8], 8'h00);
  endtask
  task automatic rdchk(input logic [16:0] a, input logic [7:0] e);
    logic [8:0] v;
    cmd(2'h1, a, 8'h00, 1'b1);
    wdone(v);
    chk(v[7:0], e);
    chk(v[8], 8'h01);
  endtask
  // ----------
  // scenarios
  // ----------
  // fresh device, single byte, fixed wait
  task automatic t_timed();
    done_mode = 2'h0;
    wr(2'h0, 17'h00123, 8'h3C);
    rdchk(17'h00123, 8'h3C);
    chk(prot, 8'h00);
  endtask
  // full page of 128 bytes, finished by bit 7 polling
  task automatic t_page_poll();
    logic [8:0] v;
    done_mode = 2'h1;
    wc = 16'h0258;
    for (int i = 0; i < 128; i++) cmd(2'h0, 17'h00400 + 17'(i), 8'(i) ^ 8'hA5, i == 127);
    wdone(v);
    rdchk(17'h00400, 8'hA5);
    rdchk(17'h0047F, 8'hDA);
  endtask
  // protected write finished by bit 6 toggling
  task automatic t_prot_toggle();
    done_mode = 2'h2;
    wc = 16'h0384;
    wr(2'h3, 17'h02000, 8'h5A);
    chk(wn < 1500, 8'h01);
    chk(prot, 8'h01);
    rdchk(17'h02000, 8'h5A);
    rdchk(17'h05555, 8'hFF);
  endtask
  // cancel, then a slow write at the top address through the busy pin
  task automatic t_cancel_busy();
    done_mode = 2'h3;
    wc = 16'h0708;
    wr(2'h2, 17'h00000, 8'h00);
    chk(prot, 8'h00);
    rdchk(17'h05555, 8'hFF);
    rdchk(17'h02AAA, 8'hFF);
    wr(2'h0, 17'h1FFFF, 8'h0F);
    rdchk(17'h1FFFF, 8'h0F);
  endtask
  // power loss holds the device in reset and refuses commands
  task automatic t_power();
    pwr_good = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    chk(res_n, 8'h00);
    chk(cmd_ready, 8'h00);
    pwr_good = 1'b1;
    repeat (10) @(posedge clk);
    #1;
    chk(res_n, 8'h01);
    rdchk(17'h00123, 8'h3C);
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    t_timed();
    t_page_poll();
    t_prot_toggle();
    t_cancel_busy();
    t_power();
    end_sim();
  end
  // watchdog well beyond the expected run
  initial begin
    #2000000;
    mismatches++;
    end_sim();
  end
endmodule
`default_nettype wire
